/* File: tvg_pkg.sv */
// Package with register map, field layout, reset values and shared types of the tone generator.
package tvg_pkg;

	// ==========================================================
	// Register map: printed offsets are indices, byte address is four times the index.
	localparam int unsigned ADDR_W = 18;
	localparam logic [15:0] IDX_CTRL = 16'hFFC0;
	localparam logic [15:0] IDX_VOLUME = 16'hFFC1;
	localparam logic [15:0] IDX_PITCH = 16'hFFC2;
	localparam logic [15:0] IDX_STATUS = 16'hFFC3;

	// ==========================================================
	// Reset values and field layout.
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_VOLUME = 8'h00;
	localparam logic [7:0] RST_PITCH = 8'h00;
	localparam int unsigned PITCH_W = 4;
	localparam int unsigned VOLUME_W = 7;
	localparam int unsigned DIV_W = 8;
	localparam logic [4:0] PITCH_BASE = 5'h11;
	localparam logic [3:0] DIV_BASE_EXP = 4'h5;
	localparam logic [7:0] CTRL_USED_MASK = 8'h8F;

	// ==========================================================
	// Bus answers.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic generator_run;
		logic [2:0] unused;
		logic output_route_select;
		logic counter_divide_select_hi;
		logic counter_divide_select_lo;
		logic input_prescale_select;
	} tvg_ctrl_t;

	typedef struct packed {
		logic tone_plain;
		logic volume_pwm;
		logic tone_shaped;
	} tvg_level_t;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b00,
		WR_RESPOND = 2'b01
	} tvg_wr_state_t;

endpackage : tvg_pkg

/* File: tvg_pwm.sv */
// Seven-bit volume pulse-width modulator.
`timescale 1ns/1ps
module tvg_pwm (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic tick_en,
	input wire logic [tvg_pkg::VOLUME_W-1:0] volume_code,
	output logic pwm_q
);

	logic [tvg_pkg::VOLUME_W-1:0] phase_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			phase_q <= '0; // R12
		else if (tick_en)
			phase_q <= phase_q + 7'h01;
	end

	// Code N high for phases 0..N, so duty is (N+1)/128; code 0 stays low.
	// The code is compared live, so a rewrite mid-period can stretch one high phase.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			pwm_q <= 1'b0;
		else
			pwm_q <= (volume_code != '0) && (phase_q <= volume_code); // R10 R11
	end

endmodule : tvg_pwm

/* File: tvg_speaker_model.sv */
// Speaker driver model that times the half periods of the tone pin.
`timescale 1ns/1ps
module tvg_speaker_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tone_in,
	output logic [15:0] tone_half_q,
	output logic [15:0] tone_edges_q
);
	logic tone_prev_q;
	logic [15:0] run_len_q;

	// ==========================================================
	// Edge timing.
	// A driver stage sees only edges, so the model times the gap between two of them.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tone_prev_q <= 1'b0;
			run_len_q <= 16'h0000;
			tone_half_q <= 16'h0000;
			tone_edges_q <= 16'h0000;
		end
		else if (tone_in != tone_prev_q)
		begin
			tone_prev_q <= tone_in;
			tone_half_q <= run_len_q;
			tone_edges_q <= tone_edges_q + 16'h0001;
			run_len_q <= 16'h0001;
		end
		else
		begin
			run_len_q <= run_len_q + 16'h0001;
		end
	end
endmodule : tvg_speaker_model

/* File: tvg_tone_div.sv */
// Prescaler, second-stage divider and pitch counter that make the basic-cycle square wave.
`timescale 1ns/1ps
module tvg_tone_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic prescale_sel,
	input wire logic [1:0] divide_sel,
	input wire logic [tvg_pkg::PITCH_W-1:0] pitch_code,
	output logic first_stage_en,
	output logic tone_q
);

	logic half_q;
	logic [tvg_pkg::DIV_W-1:0] div_q;
	logic [4:0] pitch_cnt_q;
	logic second_stage_en;
	logic [4:0] pitch_last;

	// ==========================================================
	// Terminal mask of the second stage: 2^(5+sel) first-stage ticks.
	function automatic logic [tvg_pkg::DIV_W-1:0] stage_mask(input logic [1:0] sel);
		logic [3:0] exp_v;
		exp_v = tvg_pkg::DIV_BASE_EXP + {2'h0, sel};
		stage_mask = 8'hFF >> (4'h8 - exp_v);
	endfunction : stage_mask

	assign first_stage_en = run && (prescale_sel || half_q); // R3
	assign second_stage_en = first_stage_en
		&& ((div_q & stage_mask(divide_sel)) == stage_mask(divide_sel)); // R4
	assign pitch_last = 5'(pitch_code) + tvg_pkg::PITCH_BASE - 5'h01; // R5 R6

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			half_q <= 1'b0;
		else
			half_q <= !half_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
			div_q <= '0; // R12
		else if (first_stage_en)
			div_q <= div_q + 8'h01;
	end

	// The tone toggles once per completed pitch count, so one tone period is two counts.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			pitch_cnt_q <= '0;
			tone_q <= 1'b0;
		end
		else if (second_stage_en)
		begin
			if (pitch_cnt_q >= pitch_last)
			begin
				pitch_cnt_q <= '0;
				tone_q <= !tone_q; // R15
			end
			else
				pitch_cnt_q <= pitch_cnt_q + 5'h01;
		end
	end

	// ==========================================================
	// Checks.
	a_halved_rate: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && !prescale_sel && first_stage_en) |=> !first_stage_en) // R3
		else $error("Halved first stage fired on two adjacent cycles.");
	a_full_rate: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && $past(run && prescale_sel))
		|-> (div_q == $past(div_q) + 8'h01)) // R3
		else $error("Undivided first stage missed a cycle.");
	a_pitch_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		$stable(pitch_code) |-> pitch_cnt_q <= pitch_last) // R5
		else $error("Pitch counter ran past its terminal count.");
	a_tone_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && $past(run) && $changed(tone_q)) |-> $past(second_stage_en)) // R15
		else $error("Tone changed without a second stage tick.");

endmodule : tvg_tone_div

/* File: tvg_top.sv */
// Tone and volume generator with its AXI4-Lite register slave.
//
// Summary of operation
// R1: Route bit 0 drives plain tone on tone pin, volume PWM on volume pin.
// R2: Route bit 1 drives shaped tone on tone pin and releases volume pin.
// R3: First stage clock is system clock halved when prescale bit 0, else undivided.
// R4: Divide select codes 00 to 11 divide first stage by 2^5 to 2^8.
// R5: Tone frequency is fX/(pitch+17) times two to the prescale-divider exponent minus 7.
// R6: Pitch register bits 3..0 hold pitch code; 0 highest, 15 lowest frequency.
// R7: Reset clears pitch and volume registers to zero.
// R8: Software stops the generator before changing control or pitch registers.
// R9: Software writes zeros to the unused bits of all three registers.
// R10: Volume code 0 gives no duty, code N gives (N+1)/128.
// R11: Volume may change while running; one stretched high period may appear.
// R12: Run bit 0 stops counters and holds all outputs low. Here volume_pin_released still follows the route bit while stopped.
// R13: Shaped tone is the AND of square wave and volume PWM.
// R14: Software sets other control fields before setting the run bit.
// R15: Basic tone is a half-duty square wave toggled at each pitch count end.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module tvg_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tvg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tvg_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic tone_out,
	output logic volume_pwm_out,
	output logic volume_pin_released
);

	// ==========================================================
	// Registers and internal levels.
	tvg_pkg::tvg_ctrl_t ctrl_q;
	logic [tvg_pkg::VOLUME_W-1:0] volume_q;
	logic [tvg_pkg::PITCH_W-1:0] pitch_q;
	tvg_pkg::tvg_level_t level;
	logic first_stage_en;
	logic tone_raw;
	logic pwm_raw;

	tvg_pkg::tvg_wr_state_t wr_state_q;
	logic aw_held_q;
	logic w_held_q;
	logic [15:0] aw_index_q;
	logic [7:0] w_byte_q;
	logic w_lane0_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic write_hit;

	// ==========================================================
	// Address decode shared by both channels.
	function automatic logic index_mapped(input logic [15:0] idx);
		index_mapped = (idx == tvg_pkg::IDX_CTRL) || (idx == tvg_pkg::IDX_VOLUME)
			|| (idx == tvg_pkg::IDX_PITCH) || (idx == tvg_pkg::IDX_STATUS);
	endfunction : index_mapped

	function automatic logic [15:0] byte_to_index(input logic [tvg_pkg::ADDR_W-1:0] addr);
		byte_to_index = addr[tvg_pkg::ADDR_W-1:2];
	endfunction : byte_to_index

	// ==========================================================
	// Write channel: address and data are taken in either order, then one response.
	// Each waits in its own holding flag, so a master that offers them apart is still served.
	assign s_axi_awready = (wr_state_q == tvg_pkg::WR_COLLECT) && !aw_held_q;
	assign s_axi_wready = (wr_state_q == tvg_pkg::WR_COLLECT) && !w_held_q;
	assign s_axi_bvalid = (wr_state_q == tvg_pkg::WR_RESPOND);
	assign s_axi_bresp = bresp_q;
	assign do_write = (wr_state_q == tvg_pkg::WR_COLLECT) && aw_held_q && w_held_q;
	assign write_hit = do_write && w_lane0_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			aw_index_q <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			aw_index_q <= byte_to_index(s_axi_awaddr);
		end
		else if (do_write)
			aw_held_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q <= 1'b0;
			w_byte_q <= '0;
			w_lane0_q <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			w_byte_q <= s_axi_wdata[7:0];
			w_lane0_q <= s_axi_wstrb[0];
		end
		else if (do_write)
			w_held_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_q <= tvg_pkg::WR_COLLECT;
			bresp_q <= tvg_pkg::RESP_OKAY;
		end
		else
		begin
			case (wr_state_q)
				tvg_pkg::WR_COLLECT:
				begin
					if (do_write)
					begin
						wr_state_q <= tvg_pkg::WR_RESPOND;
						bresp_q <= index_mapped(aw_index_q) ? tvg_pkg::RESP_OKAY
							: tvg_pkg::RESP_SLVERR;
					end
				end
				tvg_pkg::WR_RESPOND:
				begin
					if (s_axi_bready)
						wr_state_q <= tvg_pkg::WR_COLLECT;
				end
				default:
					wr_state_q <= tvg_pkg::WR_COLLECT;
			endcase
		end
	end

	// ==========================================================
	// Register storage. Unused bits are not stored, so they always read zero.
	// Changing control or pitch while running is tolerated but may give one odd tone period.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_q <= tvg_pkg::tvg_ctrl_t'(tvg_pkg::RST_CTRL);
		else if (write_hit && aw_index_q == tvg_pkg::IDX_CTRL)
			ctrl_q <= tvg_pkg::tvg_ctrl_t'(w_byte_q & tvg_pkg::CTRL_USED_MASK); // R8 R9 R14
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			volume_q <= tvg_pkg::RST_VOLUME[tvg_pkg::VOLUME_W-1:0]; // R7
		else if (write_hit && aw_index_q == tvg_pkg::IDX_VOLUME)
			volume_q <= w_byte_q[tvg_pkg::VOLUME_W-1:0]; // R9 R11
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pitch_q <= tvg_pkg::RST_PITCH[tvg_pkg::PITCH_W-1:0]; // R7
		else if (write_hit && aw_index_q == tvg_pkg::IDX_PITCH)
			pitch_q <= w_byte_q[tvg_pkg::PITCH_W-1:0]; // R6 R8 R9
	end

	// ==========================================================
	// Read channel: one-cycle answer, status shows the live internal levels, taken before output routing.
	// Ready is withheld while an answer stands, so one read at most is under way.
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= tvg_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= index_mapped(byte_to_index(s_axi_araddr)) ? tvg_pkg::RESP_OKAY
				: tvg_pkg::RESP_SLVERR;
			case (byte_to_index(s_axi_araddr))
				tvg_pkg::IDX_CTRL: rdata_q <= {24'h000000, ctrl_q};
				tvg_pkg::IDX_VOLUME: rdata_q <= {25'h0, volume_q};
				tvg_pkg::IDX_PITCH: rdata_q <= {28'h0, pitch_q};
				tvg_pkg::IDX_STATUS: rdata_q <= {29'h0, level};
				default: rdata_q <= '0;
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ==========================================================
	// Tone and volume engines.
	tvg_tone_div u_tone (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(ctrl_q.generator_run),
		.prescale_sel(ctrl_q.input_prescale_select),
		.divide_sel({ctrl_q.counter_divide_select_hi, ctrl_q.counter_divide_select_lo}),
		.pitch_code(pitch_q),
		.first_stage_en(first_stage_en),
		.tone_q(tone_raw)
	);

	tvg_pwm u_pwm (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(ctrl_q.generator_run),
		.tick_en(first_stage_en),
		.volume_code(volume_q),
		.pwm_q(pwm_raw)
	);

	assign level = {tone_raw, pwm_raw, tone_raw && pwm_raw}; // R13

	// ==========================================================
	// Output routing, registered so the pins never glitch on a route change.
	// A released volume pin is held low here; the clock-output function outside takes it over.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ctrl_q.generator_run)
		begin
			tone_out <= 1'b0; // R12
			volume_pwm_out <= 1'b0;
		end
		else if (ctrl_q.output_route_select)
		begin
			tone_out <= level.tone_shaped; // R2
			volume_pwm_out <= 1'b0;
		end
		else
		begin
			tone_out <= level.tone_plain; // R1
			volume_pwm_out <= level.volume_pwm;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			volume_pin_released <= 1'b0;
		else
			volume_pin_released <= ctrl_q.output_route_select; // R2
	end

	// ==========================================================
	// Checks.
	a_stop_holds_low: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q.generator_run |=> (!tone_out && !volume_pwm_out)) // R12
		else $error("Outputs not low while stopped.");
	a_route_plain: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q.generator_run && !ctrl_q.output_route_select)
		|=> (tone_out == $past(tone_raw) && volume_pwm_out == $past(pwm_raw))) // R1
		else $error("Plain route drove the wrong levels.");
	a_route_shaped: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q.generator_run && ctrl_q.output_route_select)
		|=> (tone_out == $past(tone_raw && pwm_raw) && volume_pin_released)) // R2 R13
		else $error("Shaped route drove the wrong levels.");
	a_reset_clears: assert property (@(posedge aclk)
		!aresetn |=> (volume_q == '0 && pitch_q == '0)) // R7
		else $error("Reset left volume or pitch nonzero.");
	a_pitch_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(write_hit && aw_index_q == tvg_pkg::IDX_PITCH)
		|=> pitch_q == $past(w_byte_q[3:0])) // R6
		else $error("Pitch write not stored.");
	a_volume_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(volume_q) == '0) |-> !pwm_raw) // R10
		else $error("Volume code zero produced a high level.");
	a_volume_full: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q.generator_run && $past(ctrl_q.generator_run) && $past(volume_q) == 7'h7F)
		|-> pwm_raw) // R10
		else $error("Volume code 127 dropped low.");
	a_divider_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q.generator_run |=> (!tone_raw && !pwm_raw)) // R12
		else $error("Tone or volume engine kept running while stopped.");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid)
		else $error("Write response missing after a write.");

	// ==========================================================
	// Bus and register checks. A second request taken while an answer stands would
	// overwrite the held address or data, so refusal is checked as well as the answer.
	a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("Write channel accepted while a response was pending.");
	a_bvalid_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
		else $error("Write response stayed after it was taken.");
	a_rvalid_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
		else $error("Read answer stayed after it was taken.");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("Read answer missing after an address.");
	a_resp_origin: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_axi_bvalid) |-> $past(do_write))
		else $error("Write response without a write.");
	a_read_mapped: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && index_mapped(byte_to_index(s_axi_araddr)))
		|=> (s_axi_rresp == tvg_pkg::RESP_OKAY))
		else $error("Mapped read answered with an error.");
	a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && !index_mapped(byte_to_index(s_axi_araddr)))
		|=> (s_axi_rresp == tvg_pkg::RESP_SLVERR && s_axi_rdata == '0))
		else $error("Unmapped read not refused.");
	a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(write_hit && aw_index_q == tvg_pkg::IDX_CTRL)
		|=> (ctrl_q == ($past(w_byte_q) & tvg_pkg::CTRL_USED_MASK))) // R9
		else $error("Control write not stored with unused bits dropped.");
	a_volume_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(write_hit && aw_index_q == tvg_pkg::IDX_VOLUME)
		|=> (volume_q == $past(w_byte_q[tvg_pkg::VOLUME_W-1:0]))) // R11
		else $error("Volume write not stored.");
	a_volume_released: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.output_route_select |=> !volume_pwm_out) // R2
		else $error("Volume pin driven while released.");
	a_release_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q.output_route_select |=> volume_pin_released) // R2
		else $error("Volume pin not released on shaped route.");
	a_pin_plain: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q.output_route_select |=> !volume_pin_released) // R1
		else $error("Volume pin released on plain route.");
	a_shaped_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q.output_route_select && !pwm_raw) |=> !tone_out) // R13
		else $error("Shaped tone high while volume level low.");

endmodule : tvg_top

/* File: tvg_top_tb.sv */
// Self-checking testbench of the tone and volume generator.
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tvg_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [tvg_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
	logic [tvg_pkg::ADDR_W-1:0] s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic tone_out, volume_pwm_out, volume_pin_released;
	logic [15:0] tone_half, tone_edges;
	logic [15:0] tone_hi = '0;
	logic [15:0] vol_hi = '0;
	int checked = 0;
	int miscompares = 0;
	logic [7:0] ctrl_cur = 8'h00;
	logic [7:0] cfg_ctrl [5] = '{8'h01, 8'h00, 8'h03, 8'h05, 8'h07};
	logic [3:0] cfg_pitch [5] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'h0};
	logic [6:0] vols [4] = '{7'h00, 7'h01, 7'h3F, 7'h7F};

	always #50 aclk = ~aclk;

	always @(posedge aclk)
	begin
		tone_hi <= tone_hi + 16'(tone_out);
		vol_hi <= vol_hi + 16'(volume_pwm_out);
	end

	tvg_top u_tvg_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .tone_out(tone_out), .volume_pwm_out(volume_pwm_out),
		.volume_pin_released(volume_pin_released));

	tvg_speaker_model u_tvg_speaker_model (.aclk(aclk), .aresetn(aresetn),
		.tone_in(tone_out), .tone_half_q(tone_half), .tone_edges_q(tone_edges));

	// ==========================================================
	// Bus tasks.
	// Signals change just after a rising edge; each handshake is judged at the next one.
	// One idle edge ends each task so no signal is assigned twice in one time step.
	task automatic wr(input logic [15:0] idx, input logic [7:0] data);
		logic done;
		int n;
		done = 1'b0;
		n = 0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, data};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			n++;
			if (s_axi_bvalid)
			begin
				`CHK(s_axi_bresp, tvg_pkg::RESP_OKAY)
				done = 1'b1;
			end
			else if (n > 100)
			begin
				miscompares++;
				done = 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] resp);
		logic done;
		int n;
		done = 1'b0;
		n = 0;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			n++;
			if (s_axi_rvalid)
			begin
				`CHK(s_axi_rdata, {24'h000000, exp})
				`CHK(s_axi_rresp, resp)
				done = 1'b1;
			end
			else if (n > 100)
			begin
				miscompares++;
				done = 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// ==========================================================
	// Output measurement.
	task automatic tone_check(input logic [7:0] ctrl, input logic [3:0] pitch);
		int h, n;
		logic [15:0] e0;
		h = (int'(pitch) + 17) << (5 + int'(ctrl[2:1]) + (ctrl[0] ? 0 : 1));
		n = 0;
		wr(tvg_pkg::IDX_CTRL, ctrl_cur & 8'h0F);
		wr(tvg_pkg::IDX_CTRL, ctrl & 8'h0F);
		wr(tvg_pkg::IDX_PITCH, {4'h0, pitch});
		wr(tvg_pkg::IDX_CTRL, ctrl | 8'h80);
		ctrl_cur = ctrl | 8'h80;
		e0 = tone_edges;
		while (tone_edges < e0 + 16'h0003 && n < 20000)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK(n < 20000, 1'b1)
		`CHK(tone_half, h[15:0])
	endtask : tone_check

	task automatic window(input int cycles, output logic [15:0] t, output logic [15:0] v);
		logic [15:0] t0, v0;
		t0 = tone_hi;
		v0 = vol_hi;
		repeat (cycles) @(posedge aclk);
		t = tone_hi - t0;
		v = vol_hi - v0;
	endtask : window

	task automatic print_verdict;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (80000) @(posedge aclk);
		miscompares++;
		print_verdict();
	end

	initial
	begin : main
		logic [15:0] t, v;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(tvg_pkg::IDX_CTRL, 8'h00, tvg_pkg::RESP_OKAY);
		rd(tvg_pkg::IDX_VOLUME, 8'h00, tvg_pkg::RESP_OKAY);
		rd(tvg_pkg::IDX_PITCH, 8'h00, tvg_pkg::RESP_OKAY);
		rd(16'h0010, 8'h00, tvg_pkg::RESP_SLVERR);
		wr(tvg_pkg::IDX_PITCH, 8'h0F);
		rd(tvg_pkg::IDX_PITCH, 8'h0F, tvg_pkg::RESP_OKAY);
		for (int i = 0; i < 5; i++)
			tone_check(cfg_ctrl[i], cfg_pitch[i]);
		rd(tvg_pkg::IDX_CTRL, 8'h87, tvg_pkg::RESP_OKAY);
		tone_check(8'h01, 4'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(tvg_pkg::IDX_VOLUME, {1'b0, vols[i]});
			repeat (300) @(posedge aclk);
			window(256, t, v);
			`CHK(v, (vols[i] == 7'h00) ? 16'h0000 : 16'(2 * (vols[i] + 1)))
		end
		`CHK(volume_pin_released, 1'b0)
		tone_check(8'h09, 4'h0);
		`CHK(volume_pin_released, 1'b1)
		window(256, t, v);
		`CHK(v, 16'h0000)
		wr(tvg_pkg::IDX_VOLUME, 8'h00);
		repeat (300) @(posedge aclk);
		window(1200, t, v);
		`CHK(t, 16'h0000)
		wr(tvg_pkg::IDX_CTRL, ctrl_cur & 8'h0F);
		wr(tvg_pkg::IDX_CTRL, 8'h01);
		wr(tvg_pkg::IDX_VOLUME, 8'h7F);
		repeat (4) @(posedge aclk);
		window(1200, t, v);
		`CHK(t, 16'h0000)
		`CHK(v, 16'h0000)
		rd(tvg_pkg::IDX_STATUS, 8'h00, tvg_pkg::RESP_OKAY);
		print_verdict();
	end
endmodule : tvg_top_tb
